// >>> logic/ipv_pkg.sv
`default_nettype none
package ipv_pkg;
    // APB register byte offsets
    localparam logic [7:0] REG_PRIO   = 8'h00;
    localparam logic [7:0] REG_LOC_EN = 8'h04;
    localparam logic [7:0] REG_RTCTL  = 8'h08;
    localparam logic [7:0] REG_STAT   = 8'h0c;

    localparam logic [4:0] PSEL_RST = 5'h06;
    localparam logic [4:0] PSEL_MIN = 5'h06;
    localparam logic [4:0] PSEL_MAX = 5'h19;
    localparam int         NSRC     = 20;
    localparam logic [2:0] RATE_MAX = 3'h5;

    // Vector table placement
    localparam logic [15:0] VBASE_NORM = 16'hffc0;
    localparam logic [15:0] VBASE_SPEC = 16'hbfc0;
    localparam logic [5:0]  VOFF_NONMASKABLE_REQUEST_PIN  = 6'h34;
    localparam logic [5:0]  VOFF_SWI   = 6'h36;
    localparam logic [5:0]  VOFF_ILL   = 6'h38;
    localparam logic [5:0]  VOFF_WDOG  = 6'h3a;
    localparam logic [5:0]  VOFF_CMF   = 6'h3c;
    localparam logic [5:0]  VOFF_RST   = 6'h3e;

    // Maskable slots: slot n is promotion code n+6
    localparam logic [5:0] SLOT_VOFF [NSRC] = '{
        6'h32, 6'h30, 6'h2e, 6'h2c, 6'h2a, 6'h28, 6'h26, 6'h24, 6'h22, 6'h20,
        6'h1e, 6'h1c, 6'h1a, 6'h18, 6'h16, 6'h14, 6'h12, 6'h10, 6'h0e, 6'h0c};
    localparam logic [4:0] SLOT_PRIO [NSRC] = '{
        5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e,
        5'h11, 5'h13, 5'h14, 5'h17, 5'h18, 5'h0f, 5'h10, 5'h12, 5'h15, 5'h16};

    typedef enum logic [2:0] {
        ST_BOOT  = 3'h0,
        ST_IDLE  = 3'h1,
        ST_STACK = 3'h2,
        ST_FHI   = 3'h3,
        ST_FLO   = 3'h4,
        ST_LOAD  = 3'h5,
        ST_HOLD  = 3'h6
    } ipv_state_t;
endpackage : ipv_pkg
`default_nettype wire

// >>> logic/ipv_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1: Twenty maskable sources, all but the external pin locally enabled
// R2: Pseudo-NMI pin blocked in reset, after acceptance
// R3: Vector base set by operating mode
// R4: Pin requests gated by their class bits
// R5: Traps and reset vectors are never masked
// R6: Serial sources at their vectors and priorities
// R7: Pulse accumulator and overflow vectors, priorities
// R8: Output compare vectors and priorities
// R9: Input capture and periodic vectors, priorities
// R10: Software trap waits, then locks out others
// R11: Illegal opcode traps and locks out others
// R12: Periodic flag after one full period
// R13: Reset sets both class mask bits
// R14: Pseudo-NMI mask cannot be set again
// R15: Maskable accept sets maskable mask only
// R16: Pseudo-NMI accept sets both masks
// R17: Return restores both masks from stack
// R18: Fixed order among non-maskable sources
// R19: Promotion written only while maskable masked
// R20: Promoted source keeps gating and vector
// R21: Lowest six vector pairs stay unused
// R22: Promotion resets to external pin
// R23: Vector fetched high byte then low
module ipv_top #(
    parameter int RTI_BASE_CYCLES = 8192
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Pins
    input  wire logic        irq_pin_n,
    input  wire logic        nonmaskable_request_pin_n,
    input  wire logic        mode_a,
    input  wire logic        mode_b,
    // Peripheral and failure requests
    input  wire logic [17:0] periph_req,
    input  wire logic        watchdog_failure,
    input  wire logic        clkmon_failure,
    // CPU sequencer
    input  wire logic        cpu_take_ok,
    input  wire logic        software_trap_instruction,
    input  wire logic        illegal_opcode,
    input  wire logic        flags_stacked,
    input  wire logic        first_insn_done,
    input  wire logic        return_from_interrupt,
    input  wire logic        rti_x,
    input  wire logic        rti_i,
    input  wire logic        flag_xfer,
    input  wire logic        xfer_x,
    input  wire logic        xfer_i,
    output logic             stack_req,
    output logic             x_mask,
    output logic             i_mask,
    // Vector fetch
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             boot_rom_sel,
    input  wire logic [7:0]  mem_rdata,
    output logic [15:0]      pc_value,
    output logic             pc_load,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    typedef struct packed {
        ipv_pkg::ipv_state_t st;
        logic [3:0]          sync1;
        logic [3:0]          sync2;
        logic [1:0]          boot_cnt;
        logic                special;
        logic                boot_int;
        logic                x;
        logic                i;
        logic                set_x;
        logic                trap;
        logic                reset_type;
        logic [5:0]          voff;
        logic [7:0]          pc_hi;
        logic [15:0]         pc;
        logic                pc_load;
        logic                mem_rd;
        logic [15:0]         mem_addr;
        logic                boot_sel;
        logic [4:0]          psel;
        logic [19:1]         en;
        logic [2:0]          rate;
        logic [19:0]         rti_cnt;
        logic                rti_flag;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } ipv_regs_t;

    ipv_regs_t s_q;
    ipv_regs_t s_d;

    localparam ipv_regs_t RESET_VAL = '{
        st: ipv_pkg::ST_BOOT, sync1: 4'hf, sync2: 4'hf, boot_cnt: 2'h0,
        special: 1'b0, boot_int: 1'b0, x: 1'b1, i: 1'b1, set_x: 1'b1,
        trap: 1'b0, reset_type: 1'b1, voff: ipv_pkg::VOFF_RST,
        pc_hi: 8'h00, pc: 16'h0000, pc_load: 1'b0, mem_rd: 1'b0,
        mem_addr: 16'h0000, boot_sel: 1'b0, psel: ipv_pkg::PSEL_RST,
        en: 19'h00000, rate: 3'h0, rti_cnt: 20'h00000, rti_flag: 1'b0,
        prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};

    // Periodic period in cycles; codes above five use the slowest rate
    logic [2:0]  rate_eff;
    logic [19:0] rti_last;
    assign rate_eff = (s_q.rate > ipv_pkg::RATE_MAX) ? ipv_pkg::RATE_MAX : s_q.rate;
    assign rti_last = (20'(RTI_BASE_CYCLES) << rate_eff) - 20'h00001;

    always_comb begin
        logic [19:0] req;
        logic [19:0] act;
        logic        found;
        logic [4:0]  bp;
        logic [4:0]  bs;
        logic [4:0]  ps;
        logic [15:0] base;
        logic        acc;
        logic        wr;
        logic        nonmaskable_request_pin_on;
        logic        go;
        logic [5:0]  go_off;
        logic        go_x;
        logic        go_trap;
        logic        go_rst;
        req = '0;
        act = '0;
        found = 1'b0;
        bp = '0;
        bs = '0;
        ps = '0;
        base = '0;
        acc = 1'b0;
        wr = 1'b0;
        nonmaskable_request_pin_on = 1'b0;
        go = 1'b0;
        go_off = '0;
        go_x = 1'b0;
        go_trap = 1'b0;
        go_rst = 1'b0;
        s_d = s_q;
        s_d.pc_load = 1'b0;

        // Two-flop pin synchronisers
        s_d.sync1 = {mode_b, mode_a, nonmaskable_request_pin_n, irq_pin_n};
        s_d.sync2 = s_q.sync1;

        // Periodic timer runs from the first cycle after reset
        if (s_q.rti_cnt >= rti_last) begin
            s_d.rti_cnt = '0;
            s_d.rti_flag = 1'b1; // R12
        end else begin
            s_d.rti_cnt = s_q.rti_cnt + 20'h00001;
        end

        // Maskable requests behind the class bit, all but the pin also behind a local enable
        req = {periph_req, s_q.rti_flag, ~s_q.sync2[0]};
        act[0] = req[0] & ~s_q.i; // R4
        for (int k = 1; k < ipv_pkg::NSRC; k++) begin
            act[k] = req[k] & s_q.en[k] & ~s_q.i; // R1 R20
        end
        for (int k = 0; k < ipv_pkg::NSRC; k++) begin
            if (act[k] && (!found || ipv_pkg::SLOT_PRIO[k] < bp)) begin // R6 R7 R8 R9
                found = 1'b1;
                bp = ipv_pkg::SLOT_PRIO[k];
                bs = 5'(k);
            end
        end
        // Unused promotion codes fall back to the external pin
        if (s_q.psel >= ipv_pkg::PSEL_MIN && s_q.psel <= ipv_pkg::PSEL_MAX) begin
            ps = s_q.psel - ipv_pkg::PSEL_MIN;
        end
        if (act[ps]) begin
            bs = ps; // R20
        end
        nonmaskable_request_pin_on = ~s_q.sync2[1] & ~s_q.x; // R2 R4

        // Fixed order of acceptance in idle
        if (clkmon_failure) begin // R18 R5
            go = 1'b1;
            go_off = ipv_pkg::VOFF_CMF;
            go_rst = 1'b1;
        end else if (watchdog_failure) begin
            go = 1'b1;
            go_off = ipv_pkg::VOFF_WDOG;
            go_rst = 1'b1;
        end else if (illegal_opcode) begin // R11
            go = 1'b1;
            go_off = ipv_pkg::VOFF_ILL;
            go_trap = 1'b1;
        end else if (software_trap_instruction) begin // R10
            go = 1'b1;
            go_off = ipv_pkg::VOFF_SWI;
            go_trap = 1'b1;
        end else if (nonmaskable_request_pin_on && cpu_take_ok) begin
            go = 1'b1;
            go_off = ipv_pkg::VOFF_NONMASKABLE_REQUEST_PIN;
            go_x = 1'b1;
        end else if (found && cpu_take_ok) begin
            go = 1'b1;
            go_off = ipv_pkg::SLOT_VOFF[bs]; // R21
        end

        base = s_q.special ? ipv_pkg::VBASE_SPEC : ipv_pkg::VBASE_NORM; // R3

        // Flag register transfer and return
        if (flag_xfer) begin
            s_d.i = xfer_i;
            s_d.x = s_q.x & xfer_x; // R14
        end
        if (return_from_interrupt) begin
            s_d.i = rti_i; // R17
            s_d.x = rti_x; // R17
        end

        unique case (s_q.st)
            ipv_pkg::ST_BOOT: begin
                // Straps are caught once the synchronisers have filled
                s_d.boot_cnt = s_q.boot_cnt + 2'h1;
                if (s_q.boot_cnt == 2'h3) begin
                    s_d.special = ~s_q.sync2[3];
                    s_d.boot_int = ~s_q.sync2[3] & ~s_q.sync2[2];
                    s_d.st = ipv_pkg::ST_FHI;
                    s_d.mem_rd = 1'b1;
                    s_d.mem_addr = (~s_q.sync2[3] ? ipv_pkg::VBASE_SPEC : ipv_pkg::VBASE_NORM)
                                   | {10'h000, ipv_pkg::VOFF_RST};
                    s_d.boot_sel = ~s_q.sync2[3] & ~s_q.sync2[2];
                end
            end
            ipv_pkg::ST_IDLE: begin
                if (go) begin
                    s_d.voff = go_off;
                    s_d.set_x = go_x | go_rst;
                    s_d.trap = go_trap;
                    s_d.reset_type = go_rst;
                    if (go_rst) begin
                        s_d.x = 1'b1;
                        s_d.i = 1'b1;
                        s_d.st = ipv_pkg::ST_FHI;
                        s_d.mem_rd = 1'b1;
                        s_d.mem_addr = base | {10'h000, go_off};
                        s_d.boot_sel = s_q.boot_int;
                    end else begin
                        s_d.st = ipv_pkg::ST_STACK;
                    end
                end
            end
            ipv_pkg::ST_STACK: begin
                if (flags_stacked) begin
                    s_d.i = 1'b1; // R10 R15 R16
                    s_d.x = s_q.x | s_q.set_x; // R15 R16
                    s_d.st = ipv_pkg::ST_FHI;
                    s_d.mem_rd = 1'b1;
                    s_d.mem_addr = base | {10'h000, s_q.voff};
                    s_d.boot_sel = s_q.boot_int;
                end
            end
            ipv_pkg::ST_FHI: begin
                s_d.st = ipv_pkg::ST_FLO;
                s_d.mem_addr = s_q.mem_addr | 16'h0001; // R23
            end
            ipv_pkg::ST_FLO: begin
                s_d.pc_hi = mem_rdata; // R23
                s_d.mem_rd = 1'b0;
                s_d.st = ipv_pkg::ST_LOAD;
            end
            ipv_pkg::ST_LOAD: begin
                s_d.pc = {s_q.pc_hi, mem_rdata}; // R23
                s_d.pc_load = 1'b1;
                s_d.boot_sel = 1'b0;
                s_d.st = s_q.trap ? ipv_pkg::ST_HOLD : ipv_pkg::ST_IDLE;
            end
            ipv_pkg::ST_HOLD: begin
                if (first_insn_done) begin // R10 R11
                    s_d.st = ipv_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.st = ipv_pkg::ST_IDLE;
            end
        endcase

        // APB slave, one wait state per transfer
        acc = psel & penable;
        wr = acc & s_q.pready & pwrite;
        if (acc && !s_q.pready) begin
            s_d.pready = 1'b1;
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            unique case (paddr)
                ipv_pkg::REG_PRIO:   s_d.prdata[4:0] = s_q.psel;
                ipv_pkg::REG_LOC_EN: s_d.prdata[19:0] = {s_q.en, 1'b1};
                ipv_pkg::REG_RTCTL:  s_d.prdata[2:0] = s_q.rate;
                ipv_pkg::REG_STAT:   s_d.prdata[7:0] = {s_q.st, s_q.boot_int, s_q.special,
                                                        s_q.i, s_q.x, s_q.rti_flag};
                default:             s_d.pslverr = 1'b1;
            endcase
        end else begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end
        if (wr) begin
            unique case (paddr)
                ipv_pkg::REG_PRIO: begin
                    if (s_q.i) begin
                        s_d.psel = pwdata[4:0]; // R19
                    end
                end
                ipv_pkg::REG_LOC_EN: s_d.en = pwdata[19:1];
                ipv_pkg::REG_RTCTL:  s_d.rate = pwdata[2:0];
                ipv_pkg::REG_STAT: begin
                    // Set wins over a same-cycle clear
                    if (pwdata[0] && s_q.rti_cnt < rti_last) begin
                        s_d.rti_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= RESET_VAL; // R13 R22 R2
        end else begin
            s_q <= s_d;
        end
    end

    assign stack_req = (s_q.st == ipv_pkg::ST_STACK);
    assign x_mask = s_q.x;
    assign i_mask = s_q.i;
    assign mem_addr = s_q.mem_addr;
    assign mem_rd = s_q.mem_rd;
    assign boot_rom_sel = s_q.boot_sel;
    assign pc_value = s_q.pc;
    assign pc_load = s_q.pc_load;
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;

    sequence seq_hi_lo;
        mem_rd && !mem_addr[0] ##1 mem_rd && mem_addr[0];
    endsequence
    sequence seq_load;
        !mem_rd ##1 pc_load;
    endsequence

    chk_fetch_order: assert property (@(posedge ref_clk) disable iff (!arst_n) // R23
        $rose(mem_rd) |-> seq_hi_lo ##1 seq_load)
        else $error("vector fetch order wrong");

    chk_vec_base: assert property (@(posedge ref_clk) disable iff (!arst_n) // R3
        mem_rd |-> mem_addr[15:6] == (s_q.special ? ipv_pkg::VBASE_SPEC[15:6] : ipv_pkg::VBASE_NORM[15:6]))
        else $error("vector base wrong for mode");

    chk_prio_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R19
        psel && penable && pready && pwrite && paddr == ipv_pkg::REG_PRIO && !i_mask
        |=> $stable(s_q.psel))
        else $error("promotion written while unmasked");

    chk_xmask_stay: assert property (@(posedge ref_clk) disable iff (!arst_n) // R14
        !x_mask && flag_xfer && !return_from_interrupt && !stack_req
        && s_q.st != ipv_pkg::ST_IDLE |=> !x_mask)
        else $error("pseudo-NMI mask set by transfer");

    chk_stack_x: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
        stack_req && flags_stacked && s_q.set_x && !return_from_interrupt |=> x_mask && i_mask)
        else $error("masks not set on pseudo-NMI");

    chk_stack_i: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
        stack_req && flags_stacked && !s_q.set_x && !flag_xfer && !return_from_interrupt
        |=> i_mask && x_mask == $past(x_mask))
        else $error("maskable accept changed masks wrongly");

    chk_trap_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
        s_q.st == ipv_pkg::ST_HOLD && !first_insn_done |=> s_q.st == ipv_pkg::ST_HOLD && !stack_req)
        else $error("trap lockout released early");

    chk_rti_period: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
        $rose(s_q.rti_flag) |-> $past(s_q.rti_cnt) >= $past(rti_last))
        else $error("periodic flag before full period");

    chk_rti_restore: assert property (@(posedge ref_clk) disable iff (!arst_n) // R17
        return_from_interrupt && s_q.st == ipv_pkg::ST_HOLD |=> x_mask == $past(rti_x) && i_mask == $past(rti_i))
        else $error("return did not restore masks");

endmodule : ipv_top
`default_nettype wire

// >>> testbench/ipv_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ipv_cpu_model #(
    parameter int INSN_WAIT = 6
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Pace of the stacking answer
    input  wire logic [3:0]  stack_wait,
    // From the block
    input  wire logic        stack_req,
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    input  wire logic        pc_load,
    // To the block
    output logic             flags_stacked,
    output logic             first_insn_done,
    output logic [7:0]       mem_rdata
);
    logic [3:0] stk_cnt;
    int         insn_cnt;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_stacked   <= 1'b0;
            first_insn_done <= 1'b0;
            mem_rdata       <= 8'h00;
            stk_cnt         <= 4'h0;
            insn_cnt        <= 0;
        end else begin
            flags_stacked   <= 1'b0;
            first_insn_done <= 1'b0;
            // Slow stacking is possible, the pulse never repeats for one request
            if (stack_req && !flags_stacked) begin
                stk_cnt <= stk_cnt + 4'h1;
                if (stk_cnt == stack_wait) begin
                    flags_stacked <= 1'b1;
                    stk_cnt       <= 4'h0;
                end
            end
            if (pc_load) begin
                insn_cnt <= 1;
            end else if (insn_cnt != 0) begin
                insn_cnt <= insn_cnt + 1;
                if (insn_cnt == INSN_WAIT) begin
                    first_insn_done <= 1'b1;
                    insn_cnt        <= 0;
                end
            end
            // Each vector byte holds its own address low byte; idle bus toggles
            mem_rdata <= mem_rd ? mem_addr[7:0] : ~mem_rdata;
        end
    end
endmodule : ipv_cpu_model
`default_nettype wire

// >>> testbench/interrupt_priority_vectoring_test.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_vectoring_test;
    logic ref_clk = 1'b0, arst_n = 1'b0, irq_pin_n = 1'b1, nmi_n = 1'b1, mode_a = 1'b0, mode_b = 1'b1;
    logic [17:0] periph_req = '0;
    logic wdog = 1'b0, cmon = 1'b0, trap = 1'b0, ill = 1'b0, fs, fid, rfi = 1'b0, rti_x = 1'b0, rti_i = 1'b0;
    logic flag_xfer = 1'b0, xfer_x = 1'b0, xfer_i = 1'b0, stack_req, x_mask, i_mask, mem_rd, rom_sel, pc_load;
    logic [15:0] mem_addr, pc_value;
    logic [7:0]  mem_rdata, paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  stack_wait = 4'h0;
    logic        er;
    int          fails = 0;
    int          n_compared = 0;
    logic [7:0]  vtab [18] = '{8'hee, 8'hec, 8'hea, 8'he8, 8'he6, 8'he4, 8'he2, 8'he0, 8'hde,
                               8'hdc, 8'hda, 8'hd8, 8'hd6, 8'hd4, 8'hd2, 8'hd0, 8'hce, 8'hcc};

    always #10 ref_clk = ~ref_clk;

    ipv_top #(.RTI_BASE_CYCLES(16)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .irq_pin_n(irq_pin_n),
        .nonmaskable_request_pin_n(nmi_n), .mode_a(mode_a), .mode_b(mode_b), .periph_req(periph_req),
        .watchdog_failure(wdog), .clkmon_failure(cmon), .cpu_take_ok(1'b1), .software_trap_instruction(trap),
        .illegal_opcode(ill), .flags_stacked(fs), .first_insn_done(fid), .return_from_interrupt(rfi),
        .rti_x(rti_x), .rti_i(rti_i), .flag_xfer(flag_xfer), .xfer_x(xfer_x), .xfer_i(xfer_i),
        .stack_req(stack_req), .x_mask(x_mask), .i_mask(i_mask), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .boot_rom_sel(rom_sel), .mem_rdata(mem_rdata), .pc_value(pc_value), .pc_load(pc_load), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    ipv_cpu_model cpu (.ref_clk(ref_clk), .arst_n(arst_n), .stack_wait(stack_wait), .stack_req(stack_req),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .pc_load(pc_load), .flags_stacked(fs),
        .first_insn_done(fid), .mem_rdata(mem_rdata));

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            chk("apb_wait", 0, 1);
            final_report();
        end
    endtask : apb

    // Return (sel=1) or flag transfer (sel=0) carrying new mask values
    task automatic cf(input logic sel, input logic x, input logic i);
        @(posedge ref_clk);
        rfi       <= sel;
        flag_xfer <= !sel;
        {rti_x, rti_i, xfer_x, xfer_i} <= {x, i, x, i};
        @(posedge ref_clk);
        rfi       <= 1'b0;
        flag_xfer <= 1'b0;
    endtask : cf

    task automatic ev(input logic [3:0] m);
        @(posedge ref_clk);
        {cmon, wdog, ill, trap} <= m;
        @(posedge ref_clk);
        {cmon, wdog, ill, trap} <= 4'h0;
    endtask : ev

    task automatic sv(input logic [7:0] hb, input logic [7:0] v, input logic st, input logic ex,
                      input logic ei, input logic rom);
        logic        seen_st;
        logic        got;
        logic [15:0] a;
        logic        rs;
        int          n;
        {seen_st, got, a, rs} = '0;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (stack_req === 1'b1) seen_st = 1'b1;
            if (mem_rd === 1'b1 && !got) begin
                {got, a, rs} = {1'b1, mem_addr, rom_sel};
            end
            if (pc_load === 1'b1) break;
        end
        if (n == 100) begin
            chk("pc_load_wait", 0, 1);
            final_report();
        end
        chk("vector_addr", a, {hb, v});
        chk("boot_rom_sel", rs, rom);
        chk("pc_value", pc_value, {v, v | 8'h01});
        chk("stacked", seen_st, st);
        chk("x_mask", x_mask, ex);
        chk("i_mask", i_mask, ei);
    endtask : sv

    task automatic rst(input logic a, input logic b);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        mode_a <= a;
        mode_b <= b;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        chk("reset_masks", {x_mask, i_mask}, 2'b11);
        sv(b ? 8'hff : 8'hbf, 8'hfe, 1'b0, 1'b1, 1'b1, !a && !b);
    endtask : rst

    task automatic t_periodic();
        apb(1'b0, 8'h0c, '0);
        chk("periodic_early", rd[0], 1'b0);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, 8'h0c, '0);
        chk("periodic_set", rd[2:0], 3'b111);
        cf(1'b0, 1'b1, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("local_gate", stack_req, 1'b0);
        stack_wait <= 4'h4;
        apb(1'b1, 8'h04, 32'h2);
        sv(8'hff, 8'hf0, 1'b1, 1'b1, 1'b1, 1'b0);
        stack_wait <= 4'h0;
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h04, 32'h000ffffc);
    endtask : t_periodic

    task automatic t_maskable();
        for (int k = 0; k < 18; k++) begin
            periph_req <= 18'h1 << k;
            cf(1'b1, 1'b1, 1'b0);
            sv(8'hff, vtab[k], 1'b1, 1'b1, 1'b1, 1'b0);
        end
        periph_req <= '0;
        irq_pin_n <= 1'b0;
        cf(1'b1, 1'b1, 1'b0);
        sv(8'hff, 8'hf2, 1'b1, 1'b1, 1'b1, 1'b0);
        irq_pin_n <= 1'b1;
    endtask : t_maskable

    task automatic t_promote();
        apb(1'b0, 8'h00, '0);
        chk("prio_reset", rd, 32'h6);
        periph_req <= '1;
        cf(1'b1, 1'b1, 1'b0);
        sv(8'hff, 8'hee, 1'b1, 1'b1, 1'b1, 1'b0);
        apb(1'b1, 8'h00, 32'h14);
        cf(1'b1, 1'b1, 1'b0);
        sv(8'hff, 8'hd6, 1'b1, 1'b1, 1'b1, 1'b0);
        periph_req <= '0;
        // Unmask first so the next promotion write must be refused
        cf(1'b0, 1'b1, 1'b0);
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b0, 8'h00, '0);
        chk("prio_locked", rd, 32'h14);
        apb(1'b0, 8'h10, '0);
        chk("unmapped", {er, rd[30:0]}, {1'b1, 31'h0});
    endtask : t_promote

    task automatic t_pseudo_nmi();
        cf(1'b0, 1'b0, 1'b0);
        cf(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge ref_clk);
        chk("x_stays_clear", x_mask, 1'b0);
        nmi_n <= 1'b0;
        sv(8'hff, 8'hf4, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("pin_blocked", stack_req, 1'b0);
        nmi_n <= 1'b1;
        cf(1'b1, 1'b0, 1'b1);
        nmi_n <= 1'b0;
        ev(4'b0001);
        sv(8'hff, 8'hf6, 1'b1, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        chk("trap_lock", stack_req, 1'b0);
        sv(8'hff, 8'hf4, 1'b1, 1'b1, 1'b1, 1'b0);
        nmi_n <= 1'b1;
    endtask : t_pseudo_nmi

    task automatic t_nonmaskable();
        ev(4'b1111);
        sv(8'hff, 8'hfc, 1'b0, 1'b1, 1'b1, 1'b0);
        ev(4'b0100);
        sv(8'hff, 8'hfa, 1'b0, 1'b1, 1'b1, 1'b0);
        ev(4'b0011);
        sv(8'hff, 8'hf8, 1'b1, 1'b1, 1'b1, 1'b0);
        repeat (10) @(posedge ref_clk);
        ev(4'b0001);
        sv(8'hff, 8'hf6, 1'b1, 1'b1, 1'b1, 1'b0);
    endtask : t_nonmaskable

    initial begin
        rst(1'b1, 1'b0);
        rst(1'b0, 1'b0);
        rst(1'b0, 1'b1);
        t_periodic();
        t_maskable();
        t_promote();
        t_pseudo_nmi();
        t_nonmaskable();
        final_report();
    end
endmodule : interrupt_priority_vectoring_test
`default_nettype wire
